// ==== hw/ipc_pkg.sv ====
// Constants and types of the interrupt priority and sense configuration block
// Operation
// RQ1: Five 16-bit read/write priority registers give each source a level 0 to 15.
// RQ2: Each priority register holds four 4-bit fields, high nibble first.
// RQ3: A field is a binary level; zero lowest, all ones highest.
// RQ4: Fields map to request pins 0-7, then fixed peripheral groups, last nibble reserved.
// RQ5: Two modules sharing one field both take that field's level.
// RQ6: Reset clears all priority registers; standby leaves them unchanged.
// RQ7: Reserved low nibble of the fifth priority register reads zero; software writes zero.
// RQ8: Reset initialises the sense control register; standby keeps it.
// RQ9: Sense control bit 15 reads the live non-maskable pin level, writes ignored.
// RQ10: Sense control bits 14 to 9 read zero; software writes zero.
// RQ11: Bit 8 picks non-maskable edge: 0 falling (reset), 1 rising.
// RQ12: Bits 7 to 0 set pins 0 to 7 sensing: 0 low level, 1 falling edge.
// RQ13: Equal levels requesting together resolve by fixed default ranking, lower vector wins.
// RQ14: Sources within one shared field rank by fixed order software cannot change.
// RQ15: Selected request reaches the CPU only if its level exceeds the CPU mask.
// RQ16: Edge requests latch pending until accepted; level requests pend only while asserted.
// RQ17: Each source has a fixed vector presented with the request.
package ipc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] OFS_PRIO_A = 12'h000;
   localparam logic [11:0] OFS_PRIO_B = 12'h004;
   localparam logic [11:0] OFS_PRIO_C = 12'h008;
   localparam logic [11:0] OFS_PRIO_D = 12'h00C;
   localparam logic [11:0] OFS_PRIO_E = 12'h010;
   localparam logic [11:0] OFS_SENSE = 12'h014;
   localparam logic [11:0] OFS_EVT_STATUS = 12'h018;
   localparam logic [11:0] OFS_EVT_CLEAR = 12'h01C;
   localparam logic [11:0] OFS_EVT_ENABLE = 12'h020;
   localparam logic [15:0] RST_PRIO = 16'h0000;
   localparam logic [7:0] RST_SENSE = 8'h00;
   localparam logic RST_NMI_EDGE = 1'b0;
   localparam logic [1:0] RST_EVT = 2'h0;
   // Sense control fields
   localparam int POS_NMI_LEVEL = 15;
   localparam int POS_NMI_EDGE = 8;
   localparam logic [15:0] PRIO_E_KEEP = 16'hFFF0;
   // Event bits
   localparam int EVT_NMI = 0;
   localparam int EVT_ACCEPT = 1;
   localparam int EVT_W = 2;
   // ----------------------------------------
   // Sources and vectors
   // ----------------------------------------
   localparam int NUM_EXT = 8;
   localparam int NUM_PERIPH = 44;
   localparam int NUM_SRC = 1 + NUM_EXT + NUM_PERIPH;
   localparam int NUM_FIELD = 20;
   localparam logic [7:0] VEC_NMI = 8'h0B;
   localparam logic [7:0] VEC_BASE = 8'h3F;
   localparam logic [43:0] PERIPH_PRESENT = 44'h33FF7777755;
   localparam logic [4:0] LVL_NMI = 5'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] vector;
      logic [3:0] level;
   } ipc_req_t;
endpackage

// ==== hw/ipc_top.sv ====
// Interrupt priority and sense configuration with request selection
`timescale 1ns/10ps
`default_nettype none
module ipc_top #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Interrupt pins and peripheral requests
   input wire logic NMI_PIN,
   input wire logic [7:0] EXTERNAL_REQUEST_PINS_N,
   input wire logic [43:0] PERIPH_REQ,
   // CPU side
   input wire logic [3:0] CPU_MASK_LEVEL,
   input wire logic CPU_ACK,
   output logic IRQ_REQ,
   output ipc_pkg::ipc_req_t IRQ_OUT,
   output logic INT_O,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   logic [15:0] prio [5];
   logic nmi_edge_sel;
   logic [7:0] sense;
   logic [ipc_pkg::EVT_W-1:0] evt_status;
   logic [ipc_pkg::EVT_W-1:0] evt_enable;
   logic [ADDR_W-1:0] aw_addr;
   logic aw_full;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_full;
   logic wr_go;
   logic [11:0] wr_ofs;
   logic [11:0] rd_ofs;
   logic [15:0] wr_mask;
   logic primed;
   logic nmi_prev;
   logic [7:0] ext_prev;
   logic nmi_pend;
   logic [7:0] ext_pend;
   logic nmi_edge;
   logic [7:0] ext_fall;
   logic accept;
   logic [3:0] field [ipc_pkg::NUM_FIELD];
   logic [ipc_pkg::NUM_SRC-1:0] src_act;
   logic [4:0] src_lvl [ipc_pkg::NUM_SRC];
   logic best_found;
   logic [4:0] best_lvl;
   logic [5:0] best_idx;
   logic next_req;
   ipc_pkg::ipc_req_t next_out;

   // ----------------------------------------
   // Write channel capture
   // ----------------------------------------
   assign wr_go = aw_full && w_full && !S_AXI_BVALID;
   assign wr_ofs = 12'(aw_addr);
   assign rd_ofs = 12'(S_AXI_ARADDR);
   assign wr_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         aw_full <= 1'b0;
         aw_addr <= '0;
         S_AXI_AWREADY <= 1'b0;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_full <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         else if (wr_go)
            aw_full <= 1'b0;
         S_AXI_AWREADY <= !aw_full && !(S_AXI_AWVALID && S_AXI_AWREADY);
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         w_full <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         S_AXI_WREADY <= 1'b0;
      end
      else
      begin
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_full <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         else if (wr_go)
            w_full <= 1'b0;
         S_AXI_WREADY <= !w_full && !(S_AXI_WVALID && S_AXI_WREADY);
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= ipc_pkg::RESP_OKAY;
      end
      else if (wr_go)
      begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= (wr_ofs > ipc_pkg::OFS_EVT_ENABLE || wr_ofs[1:0] != 2'h0) ?
                        ipc_pkg::RESP_SLVERR : ipc_pkg::RESP_OKAY;
      end
      else if (S_AXI_BREADY)
         S_AXI_BVALID <= 1'b0;
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // No standby input: nothing but reset or a write ever changes these
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         // RQ6 reset clears priorities
         for (int r = 0; r < 5; r++)
            prio[r] <= ipc_pkg::RST_PRIO;
      end
      else if (wr_go)
      begin
         // RQ1 writable priority registers
         for (int r = 0; r < 5; r++)
            if (wr_ofs == ipc_pkg::OFS_PRIO_A + 12'(4 * r))
            begin
               // RQ7 reserved nibble held zero
               if (r == 4)
                  prio[r] <= (prio[r] & ~wr_mask) | (w_data[15:0] & wr_mask
                             & ipc_pkg::PRIO_E_KEEP);
               else
                  prio[r] <= (prio[r] & ~wr_mask) | (w_data[15:0] & wr_mask);
            end
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         // RQ8 sense control initialised
         nmi_edge_sel <= ipc_pkg::RST_NMI_EDGE;
         sense <= ipc_pkg::RST_SENSE;
      end
      else if (wr_go && wr_ofs == ipc_pkg::OFS_SENSE)
      begin
         // RQ11 edge select write
         if (w_strb[1])
            nmi_edge_sel <= w_data[ipc_pkg::POS_NMI_EDGE];
         // RQ12 sense select write
         if (w_strb[0])
            sense <= w_data[7:0];
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= '0;
         S_AXI_RRESP <= ipc_pkg::RESP_OKAY;
      end
      else
      begin
         S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
         if (S_AXI_ARVALID && S_AXI_ARREADY)
         begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= ipc_pkg::RESP_OKAY;
            S_AXI_RDATA <= '0;
            case (rd_ofs)
               ipc_pkg::OFS_PRIO_A: S_AXI_RDATA <= {16'h0000, prio[0]};
               ipc_pkg::OFS_PRIO_B: S_AXI_RDATA <= {16'h0000, prio[1]};
               ipc_pkg::OFS_PRIO_C: S_AXI_RDATA <= {16'h0000, prio[2]};
               ipc_pkg::OFS_PRIO_D: S_AXI_RDATA <= {16'h0000, prio[3]};
               ipc_pkg::OFS_PRIO_E: S_AXI_RDATA <= {16'h0000, prio[4]};
               // RQ9 live pin level, RQ10 zeros
               ipc_pkg::OFS_SENSE: S_AXI_RDATA <= {16'h0000, NMI_PIN, 6'h00, nmi_edge_sel, sense};
               ipc_pkg::OFS_EVT_STATUS: S_AXI_RDATA <= {30'h0, evt_status};
               ipc_pkg::OFS_EVT_CLEAR: S_AXI_RDATA <= '0;
               ipc_pkg::OFS_EVT_ENABLE: S_AXI_RDATA <= {30'h0, evt_enable};
               default: S_AXI_RRESP <= ipc_pkg::RESP_SLVERR;
            endcase
         end
         else if (S_AXI_RREADY)
            S_AXI_RVALID <= 1'b0;
      end
   end

   // ----------------------------------------
   // Pin edge detection and pending latches
   // ----------------------------------------
   // Primed flag stops a pin held low through reset posing as an edge
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         primed <= 1'b0;
         nmi_prev <= 1'b0;
         ext_prev <= 8'hFF;
      end
      else
      begin
         primed <= 1'b1;
         nmi_prev <= NMI_PIN;
         ext_prev <= EXTERNAL_REQUEST_PINS_N;
      end
   end

   // RQ11 edge chosen by select bit
   assign nmi_edge = primed && (nmi_edge_sel ? (NMI_PIN && !nmi_prev) : (!NMI_PIN && nmi_prev));
   assign accept = CPU_ACK && IRQ_REQ;

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         nmi_pend <= 1'b0;
      else
         nmi_pend <= nmi_edge || (nmi_pend && !(accept && IRQ_OUT.vector == ipc_pkg::VEC_NMI));
   end

   genvar g;
   generate
      for (g = 0; g < ipc_pkg::NUM_EXT; g++)
      begin : g_ext
         // RQ12 pin g sensed by bit 7-g
         assign ext_fall[g] = primed && sense[7 - g] && ext_prev[g]
                              && !EXTERNAL_REQUEST_PINS_N[g];
         // RQ16 edge latched until accepted, set wins
         always_ff @(posedge CLK)
         begin
            if (!RST_N)
               ext_pend[g] <= 1'b0;
            else
               ext_pend[g] <= ext_fall[g] || (ext_pend[g] && sense[7 - g]
                  && !(accept && IRQ_OUT.vector == ipc_pkg::VEC_BASE + 8'(g + 1)));
         end
         // RQ16 level request only while pin low
         assign src_act[g + 1] = sense[7 - g] ? ext_pend[g] : !EXTERNAL_REQUEST_PINS_N[g];
      end
      for (g = 0; g < ipc_pkg::NUM_FIELD; g++)
      begin : g_field
         // RQ2 four nibbles per register, RQ3 binary level
         assign field[g] = prio[g / 4][15 - 4 * (g % 4) -: 4];
      end
      for (g = 1; g < ipc_pkg::NUM_SRC; g++)
      begin : g_lvl
         // RQ4 pins one nibble each, peripherals four vectors per nibble
         // RQ5 shared field gives both modules one level
         assign src_lvl[g] = {1'b0, field[(g <= 8) ? g - 1 : 8 + (g - 9) / 4]};
      end
      for (g = 0; g < ipc_pkg::NUM_PERIPH; g++)
      begin : g_per
         assign src_act[g + 9] = PERIPH_REQ[g] && ipc_pkg::PERIPH_PRESENT[g];
      end
   endgenerate

   assign src_act[0] = nmi_pend;
   assign src_lvl[0] = ipc_pkg::LVL_NMI;

   // ----------------------------------------
   // Selection and CPU request
   // ----------------------------------------
   always_comb
   begin
      best_found = 1'b0;
      best_lvl = 5'h00;
      best_idx = 6'h00;
      // RQ13 strictly greater wins, ties keep lower vector
      // RQ14 within-field order fixed by vector order
      for (int s = 0; s < ipc_pkg::NUM_SRC; s++)
         if (src_act[s] && (!best_found || src_lvl[s] > best_lvl))
         begin
            best_found = 1'b1;
            best_lvl = src_lvl[s];
            best_idx = 6'(s);
         end
      // RQ15 level must exceed CPU mask
      next_req = best_found && (best_lvl > {1'b0, CPU_MASK_LEVEL});
      // RQ17 fixed vector per source
      next_out.vector = (best_idx == 6'h00) ? ipc_pkg::VEC_NMI : ipc_pkg::VEC_BASE + 8'(best_idx);
      next_out.level = best_lvl[4] ? 4'hF : best_lvl[3:0];
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         IRQ_REQ <= 1'b0;
         IRQ_OUT <= '0;
      end
      else
      begin
         IRQ_REQ <= next_req && !accept;
         IRQ_OUT <= next_req ? next_out : '0;
      end
   end

   // ----------------------------------------
   // Event status and interrupt
   // ----------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         evt_status <= ipc_pkg::RST_EVT;
         evt_enable <= ipc_pkg::RST_EVT;
         INT_O <= 1'b0;
      end
      else
      begin
         // Set beats a clear in the same cycle
         evt_status[ipc_pkg::EVT_NMI] <= nmi_edge || (evt_status[ipc_pkg::EVT_NMI]
            && !(wr_go && wr_ofs == ipc_pkg::OFS_EVT_CLEAR && w_data[ipc_pkg::EVT_NMI]));
         evt_status[ipc_pkg::EVT_ACCEPT] <= accept || (evt_status[ipc_pkg::EVT_ACCEPT]
            && !(wr_go && wr_ofs == ipc_pkg::OFS_EVT_CLEAR && w_data[ipc_pkg::EVT_ACCEPT]));
         if (wr_go && wr_ofs == ipc_pkg::OFS_EVT_ENABLE && w_strb[0])
            evt_enable <= w_data[ipc_pkg::EVT_W-1:0];
         INT_O <= |(evt_status & evt_enable);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_sense_rd;
      S_AXI_ARVALID && S_AXI_ARREADY && rd_ofs == ipc_pkg::OFS_SENSE;
   endsequence
   sequence s_fall0;
      primed && sense[7] && ext_prev[0] && !EXTERNAL_REQUEST_PINS_N[0];
   endsequence
   sequence s_nmi_rise;
      primed && nmi_edge_sel && NMI_PIN && !nmi_prev;
   endsequence

   chk_prio_reset: assert property ($rose(RST_N) |-> prio[0] == 16'h0000 // RQ6
      && prio[4] == 16'h0000 && sense == 8'h00 && !nmi_edge_sel) else $error("config not reset");
   chk_resv_nibble: assert property (prio[4][3:0] == 4'h0) // RQ7
      else $error("reserved nibble nonzero");
   chk_sense_read: assert property (s_sense_rd |=> S_AXI_RDATA[15] == $past(NMI_PIN) // RQ9
      && S_AXI_RVALID && S_AXI_RDATA[14:9] == 6'h00) else $error("sense read wrong");
   chk_edge_latch: assert property (s_fall0 ##1 (!accept)[*2] |-> ext_pend[0] // RQ16
      && src_act[1]) else $error("edge request not held");
   chk_level_drop: assert property (!sense[7] && EXTERNAL_REQUEST_PINS_N[0] // RQ16
      |=> IRQ_OUT.vector != 8'h40) else $error("released level request kept");
   chk_nmi_edge: assert property (s_nmi_rise |=> nmi_pend) // RQ11
      else $error("rising edge missed");
   chk_mask_gate: assert property (IRQ_REQ && IRQ_OUT.vector != ipc_pkg::VEC_NMI // RQ15
      |-> IRQ_OUT.level > $past(CPU_MASK_LEVEL)) else $error("masked request passed");
   chk_shared_lvl: assert property (src_lvl[9] == src_lvl[11] // RQ5
      && src_lvl[9][3:0] == prio[2][15:12]) else $error("shared field differs");
   chk_tie_rank: assert property ($past(src_act[1]) && $past(src_act[2]) && !$past(accept) // RQ13
      && IRQ_REQ |-> IRQ_OUT.vector != 8'h41 || $past(src_lvl[2]) > $past(src_lvl[1]))
      else $error("tie resolved wrongly");
   chk_nmi_vector: assert property ($past(nmi_pend) && !$past(accept) |-> IRQ_REQ // RQ17
      && IRQ_OUT.vector == ipc_pkg::VEC_NMI && IRQ_OUT.level == 4'hF)
      else $error("nmi not presented");
endmodule // ipc_top
`default_nettype wire

// ==== testbench/ipc_cpu_model.sv ====
// Behavioural model of the CPU core that accepts interrupt requests
`timescale 1ns/10ps
`default_nettype none
module ipc_cpu_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bench control
   input wire logic ack_en,
   input wire logic [3:0] ack_delay,
   // Controller side
   input wire logic irq_req,
   input wire ipc_pkg::ipc_req_t irq_out,
   output logic cpu_ack,
   output logic [7:0] taken_vector
);
   logic [3:0] wait_cnt;
   // ----------------------------------------
   // Acceptance
   // ----------------------------------------
   // accept presented request, take vector
   // Ack is set from irq_req seen the cycle before, so it can arrive after the request has dropped
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cpu_ack <= 1'b0;
         wait_cnt <= 4'h0;
         taken_vector <= 8'h00;
      end
      else
      begin
         cpu_ack <= 1'b0;
         if (irq_req && ack_en && !cpu_ack)
         begin
            if (wait_cnt == ack_delay)
            begin
               cpu_ack <= 1'b1;
               taken_vector <= irq_out.vector;
               wait_cnt <= 4'h0;
            end
            else
            begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end
         else
         begin
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule // ipc_cpu_model
`default_nettype wire

// ==== testbench/ipc_top_tb_top.sv ====
// Self-checking bench of the interrupt priority and sense configuration block
`timescale 1ns/10ps
`default_nettype none
module ipc_top_tb_top;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic [31:0] rexp;
      logic [1:0] resp;
   } ipc_row_t;
   // Unmapped and misaligned rows expect an error and no effect
   localparam ipc_row_t ROWS [0:7] = '{
      '{ipc_pkg::OFS_PRIO_A, 32'hFFFFFFFF, 32'h0000FFFF, ipc_pkg::RESP_OKAY},
      '{ipc_pkg::OFS_PRIO_B, 32'h00001234, 32'h00001234, ipc_pkg::RESP_OKAY},
      '{ipc_pkg::OFS_PRIO_C, 32'h0000A5C3, 32'h0000A5C3, ipc_pkg::RESP_OKAY},
      '{ipc_pkg::OFS_PRIO_D, 32'h00005A3C, 32'h00005A3C, ipc_pkg::RESP_OKAY},
      '{ipc_pkg::OFS_PRIO_E, 32'h0000FFF0, 32'h0000FFF0, ipc_pkg::RESP_OKAY},
      '{ipc_pkg::OFS_SENSE, 32'h000001FF, 32'h000081FF, ipc_pkg::RESP_OKAY},
      '{12'h024, 32'h00000001, 32'h00000000, ipc_pkg::RESP_SLVERR},
      '{12'h002, 32'h00000001, 32'h00000000, ipc_pkg::RESP_SLVERR}};
   logic CLK, RST_N, NMI_PIN, CPU_ACK, IRQ_REQ, INT_O, ack_en;
   logic [7:0] EXTERNAL_REQUEST_PINS_N, taken_vector;
   logic [43:0] PERIPH_REQ;
   logic [3:0] CPU_MASK_LEVEL, S_AXI_WSTRB, ack_delay;
   ipc_pkg::ipc_req_t IRQ_OUT;
   logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
   logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
   logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   ipc_top u_ipc_top (.CLK(CLK), .RST_N(RST_N), .NMI_PIN(NMI_PIN),
      .EXTERNAL_REQUEST_PINS_N(EXTERNAL_REQUEST_PINS_N), .PERIPH_REQ(PERIPH_REQ),
      .CPU_MASK_LEVEL(CPU_MASK_LEVEL), .CPU_ACK(CPU_ACK), .IRQ_REQ(IRQ_REQ), .IRQ_OUT(IRQ_OUT),
      .INT_O(INT_O), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
      .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
      .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
      .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
      .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
      .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
   ipc_cpu_model u_ipc_cpu_model (.clk(CLK), .rst_n(RST_N), .ack_en(ack_en),
      .ack_delay(ack_delay), .irq_req(IRQ_REQ), .irq_out(IRQ_OUT), .cpu_ack(CPU_ACK),
      .taken_vector(taken_vector));
   // ----------------------------------------
   // Clock and timeout
   // ----------------------------------------
   initial
   begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   // Whole run needs a few hundred cycles; the ceiling leaves wide margin
   always @(posedge CLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         summarize();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge CLK);
         if (!aw_ok && S_AXI_AWREADY === 1'b1)
         begin
            aw_ok = 1'b1;
            S_AXI_AWVALID <= 1'b0;
         end
         if (!w_ok && S_AXI_WREADY === 1'b1)
         begin
            w_ok = 1'b1;
            S_AXI_WVALID <= 1'b0;
         end
      end
      while (S_AXI_BVALID !== 1'b1)
         @(posedge CLK);
      r = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
   endtask
   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do @(posedge CLK); while (S_AXI_ARREADY !== 1'b1);
      S_AXI_ARVALID <= 1'b0;
      do @(posedge CLK); while (S_AXI_RVALID !== 1'b1);
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
   endtask
   task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
      axi_read(a, rd, resp);
      check(name, rd, exp);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      axi_write(a, d, resp);
   endtask
   task automatic irq_chk(input string name, input logic req, input logic [11:0] val);
      repeat (3) @(posedge CLK);
      check(name, {19'h0, IRQ_REQ, IRQ_OUT}, {19'h0, req, val});
   endtask
   task automatic reset_chk(input string name);
      for (int i = 0; i < 6; i++)
         rd_chk("reset value", ROWS[i].addr, (i == 5) ? 32'h00008000 : 32'h0);
      rd_chk("status reset", ipc_pkg::OFS_EVT_STATUS, 32'h0);
      rd_chk("enable reset", ipc_pkg::OFS_EVT_ENABLE, 32'h0);
      check("irq reset", {19'h0, IRQ_REQ, IRQ_OUT}, 32'h0);
      $display("test %s done", name);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      RST_N = 1'b0;
      NMI_PIN = 1'b1;
      EXTERNAL_REQUEST_PINS_N = 8'hFF;
      PERIPH_REQ = 44'h0;
      CPU_MASK_LEVEL = 4'h4;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 56'h0;
      S_AXI_WSTRB = 4'hF;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
      ack_en = 1'b0;
      ack_delay = 4'h2;
      repeat (12) @(posedge CLK);
      RST_N <= 1'b1;
      reset_chk("power-on reset");
      for (int i = 0; i < 8; i++)
      begin
         axi_write(ROWS[i].addr, ROWS[i].wdata, resp);
         check("bresp", {30'h0, resp}, {30'h0, ROWS[i].resp});
         axi_read(ROWS[i].addr, rd, resp);
         check("rdata", rd, ROWS[i].rexp);
         check("rresp", {30'h0, resp}, {30'h0, ROWS[i].resp});
      end
      $display("test register rows done");
      RST_N <= 1'b0;
      repeat (2) @(posedge CLK);
      RST_N <= 1'b1;
      reset_chk("mid-run reset");
      S_AXI_WSTRB <= 4'h1;
      wr(ipc_pkg::OFS_PRIO_B, 32'h0000FFFF);
      S_AXI_WSTRB <= 4'hF;
      rd_chk("byte strobe", ipc_pkg::OFS_PRIO_B, 32'h000000FF);
      // Levels, mask and ties on level-sensed pins
      wr(ipc_pkg::OFS_PRIO_A, 32'h00005009);
      EXTERNAL_REQUEST_PINS_N <= 8'hFE;
      irq_chk("pin0 level", 1'b1, 12'h405);
      CPU_MASK_LEVEL <= 4'h5;
      irq_chk("mask equal", 1'b0, 12'h000);
      CPU_MASK_LEVEL <= 4'h4;
      EXTERNAL_REQUEST_PINS_N <= 8'hF6;
      irq_chk("higher level", 1'b1, 12'h439);
      EXTERNAL_REQUEST_PINS_N <= 8'hFF;
      irq_chk("level forgotten", 1'b0, 12'h000);
      wr(ipc_pkg::OFS_PRIO_A, 32'h00005500);
      EXTERNAL_REQUEST_PINS_N <= 8'hFC;
      irq_chk("tie pins", 1'b1, 12'h405);
      EXTERNAL_REQUEST_PINS_N <= 8'hFF;
      $display("test pin levels done");
      // Shared field of two channels
      wr(ipc_pkg::OFS_PRIO_C, 32'h00007000);
      PERIPH_REQ <= 44'h4;
      irq_chk("shared field", 1'b1, 12'h4A7);
      PERIPH_REQ <= 44'h5;
      irq_chk("within module", 1'b1, 12'h487);
      wr(ipc_pkg::OFS_PRIO_E, 32'h00000080);
      PERIPH_REQ <= 44'h20000000005;
      irq_chk("watchdog pair", 1'b1, 12'h718);
      PERIPH_REQ <= 44'h0;
      $display("test shared field done");
      // Edge-sensed pin latches until accepted
      wr(ipc_pkg::OFS_SENSE, 32'h00000080);
      wr(ipc_pkg::OFS_PRIO_A, 32'h00005000);
      EXTERNAL_REQUEST_PINS_N <= 8'hFE;
      @(posedge CLK);
      EXTERNAL_REQUEST_PINS_N <= 8'hFF;
      irq_chk("edge pending", 1'b1, 12'h405);
      ack_en <= 1'b1;
      repeat (8) @(posedge CLK);
      ack_en <= 1'b0;
      irq_chk("edge cleared", 1'b0, 12'h000);
      check("acked vector", {24'h0, taken_vector}, 32'h40);
      check("int masked", {31'h0, INT_O}, 32'h0);
      $display("test edge pin done");
      // Non-maskable edges and the event interrupt
      wr(ipc_pkg::OFS_EVT_ENABLE, 32'h00000001);
      CPU_MASK_LEVEL <= 4'hF;
      NMI_PIN <= 1'b0;
      irq_chk("nmi falling", 1'b1, 12'h0BF);
      check("int raised", {31'h0, INT_O}, 32'h1);
      rd_chk("status", ipc_pkg::OFS_EVT_STATUS, 32'h3);
      ack_en <= 1'b1;
      repeat (8) @(posedge CLK);
      ack_en <= 1'b0;
      wr(ipc_pkg::OFS_EVT_CLEAR, 32'h00000003);
      rd_chk("status cleared", ipc_pkg::OFS_EVT_STATUS, 32'h0);
      check("int cleared", {31'h0, INT_O}, 32'h0);
      wr(ipc_pkg::OFS_SENSE, 32'h00000100);
      NMI_PIN <= 1'b1;
      irq_chk("nmi rising", 1'b1, 12'h0BF);
      rd_chk("nmi level", ipc_pkg::OFS_SENSE, 32'h00008100);
      $display("test nmi done");
      summarize();
   end
endmodule // ipc_top_tb_top
`default_nettype wire
